/* File: logic/event_vectoring_defines.svh */
/*
  Constants of the event priority and vectoring unit: boot address, handler
  offsets, rank positions, mask bit positions, reset values and counts.
  Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef EVENT_VECTORING_DEFINES_SVH
`define EVENT_VECTORING_DEFINES_SVH

// -----------------------------------------------------------------------------
// Addresses and widths
// -----------------------------------------------------------------------------
`define BOOT_ADDR 32'h8000_0000
`define EVT_COUNT 28
`define OFS_WIDTH 14
`define SCALL_PC_STEP 32'h0000_0002
`define FLUSH_CYCLES 2'h2

// -----------------------------------------------------------------------------
// Rank positions, bit index equals the rank value
// -----------------------------------------------------------------------------
`define RK_RESET 5'h00
`define RK_DEBUG 5'h01
`define RK_UNRECOV 5'h02
`define RK_MULTI_HIT 5'h03
`define RK_BUS_DATA 5'h04
`define RK_BUS_INSTR 5'h05
`define RK_NMI 5'h06
`define RK_INT3 5'h07
`define RK_INT0 5'h0a
`define RK_INSTR_ADDR 5'h0b
`define RK_IMISS 5'h0c
`define RK_IPROT 5'h0d
`define RK_BKPT 5'h0e
`define RK_ILLEGAL 5'h0f
`define RK_UNIMPL 5'h10
`define RK_PRIV 5'h11
`define RK_FLOAT 5'h12
`define RK_COPROC 5'h13
`define RK_SCALL 5'h14
`define RK_DADDR_RD 5'h15
`define RK_DADDR_WR 5'h16
`define RK_DMISS_RD 5'h17
`define RK_DMISS_WR 5'h18
`define RK_DPROT_RD 5'h19
`define RK_DPROT_WR 5'h1a
`define RK_DMOD 5'h1b

// -----------------------------------------------------------------------------
// Handler offsets from the vector base
// -----------------------------------------------------------------------------
`define OFS_UNRECOV 14'h0000
`define OFS_MULTI_HIT 14'h0004
`define OFS_BUS_DATA 14'h0008
`define OFS_BUS_INSTR 14'h000c
`define OFS_NMI 14'h0010
`define OFS_INSTR_ADDR 14'h0014
`define OFS_IPROT 14'h0018
`define OFS_BKPT 14'h001c
`define OFS_ILLEGAL 14'h0020
`define OFS_UNIMPL 14'h0024
`define OFS_PRIV 14'h0028
`define OFS_FLOAT 14'h002c
`define OFS_COPROC 14'h0030
`define OFS_DADDR_RD 14'h0034
`define OFS_DADDR_WR 14'h0038
`define OFS_DPROT_RD 14'h003c
`define OFS_DPROT_WR 14'h0040
`define OFS_DMOD 14'h0044
`define OFS_IMISS 14'h0050
`define OFS_DMISS_RD 14'h0060
`define OFS_DMISS_WR 14'h0070
`define OFS_SCALL 14'h0100

// -----------------------------------------------------------------------------
// Mask bits
// -----------------------------------------------------------------------------
`define MASK_WIDTH 7
`define MB_EM 4
`define MB_GM 5
`define MB_DM 6
`define MASK_RESET 7'h3f

`endif

/* File: logic/evt_vec_pkg.sv */
/*
  Types of the event priority and vectoring unit.
  Assumes the defines header sits beside it on the include path.
*/
`include "event_vectoring_defines.svh"

package evt_vec_pkg;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {S_BOOT, S_IDLE, S_HOLD} fsm_t;

  // One pipeline stage: its instruction and the events it raised.
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [`EVT_COUNT-1:0] events;
  } stage_evt_t;

  // State of the unit apart from the accepted stage index.
  typedef struct packed {
    fsm_t fsm;
    logic [`MASK_WIDTH-1:0] mask;
    logic redirect;
    logic [31:0] target;
    logic [31:0] ret_addr;
    logic [4:0] rank;
    logic [1:0] hold;
  } vec_state_t;

endpackage

/* File: logic/event_rank_select.sv */
/*
  Picks the best ranked event out of one event vector.
  Assumes bit zero is the highest rank and the vector is already masked.
*/
`timescale 1ns/10ps

module event_rank_select
  import evt_vec_pkg::*;
(
  input wire logic [`EVT_COUNT-1:0] events_i,
  output logic found_o,
  output logic [4:0] rank_o
);

  // ---------------------------------------------------------------------------
  // Priority encoder
  // ---------------------------------------------------------------------------
  // Scans from the lowest rank upward so the best rank is written last.
  always_comb begin
    found_o = |events_i;
    rank_o = 5'h00;
    for (int i = `EVT_COUNT - 1; i >= 0; i--) begin
      if (events_i[i]) begin
        rank_o = 5'(i);
      end
    end
  end

endmodule

/* File: logic/event_priority_vectoring.sv */
/*
  Event arbitration and handler address generation for the core.
  Assumes stage requests, interrupt requests and offsets come from logic on
  the core clock and stay asserted until accepted; the fetch stage takes the
  redirect pulse and flushes the pipeline within the hold window.
*/
`timescale 1ns/10ps

module event_priority_vectoring
  import evt_vec_pkg::*;
#(
  parameter int NUM_STAGES = 3,
  localparam int STW = (NUM_STAGES > 1) ? $clog2(NUM_STAGES) : 1
)
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire stage_evt_t [NUM_STAGES-1:0] stage_i,
  input wire logic debug_stop_i,
  input wire logic [31:0] debug_addr_i,
  input wire logic nmi_i,
  input wire logic [3:0] int_req_i,
  input wire logic [`OFS_WIDTH-1:0] int_offset_i,
  input wire logic [31:0] event_vector_base_i,
  input wire logic [31:0] first_pending_pc_i,
  input wire logic [`MASK_WIDTH-1:0] mask_clear_i,
  output logic redirect_o,
  output logic [31:0] target_o,
  output logic [31:0] ret_addr_o,
  output logic [4:0] accept_rank_o,
  output logic [STW-1:0] accept_stage_o,
  output logic [`MASK_WIDTH-1:0] mask_o
);

  // ---------------------------------------------------------------------------
  // Lookup functions
  // ---------------------------------------------------------------------------
  // Fixed handler offset of each rank; each exception has its own slot.
  function automatic logic [`OFS_WIDTH-1:0] rank_offset(input logic [4:0] rank);
    logic [`OFS_WIDTH-1:0] ofs;
    ofs = `OFS_UNRECOV;
    case (rank)
      `RK_UNRECOV: ofs = `OFS_UNRECOV;
      `RK_MULTI_HIT: ofs = `OFS_MULTI_HIT;
      `RK_BUS_DATA: ofs = `OFS_BUS_DATA;
      `RK_BUS_INSTR: ofs = `OFS_BUS_INSTR;
      `RK_NMI: ofs = `OFS_NMI;
      `RK_INSTR_ADDR: ofs = `OFS_INSTR_ADDR;
      `RK_IMISS: ofs = `OFS_IMISS;
      `RK_IPROT: ofs = `OFS_IPROT;
      `RK_BKPT: ofs = `OFS_BKPT;
      `RK_ILLEGAL: ofs = `OFS_ILLEGAL;
      `RK_UNIMPL: ofs = `OFS_UNIMPL;
      `RK_PRIV: ofs = `OFS_PRIV;
      `RK_FLOAT: ofs = `OFS_FLOAT;
      `RK_COPROC: ofs = `OFS_COPROC;
      `RK_SCALL: ofs = `OFS_SCALL;
      `RK_DADDR_RD: ofs = `OFS_DADDR_RD;
      `RK_DADDR_WR: ofs = `OFS_DADDR_WR;
      `RK_DMISS_RD: ofs = `OFS_DMISS_RD;
      `RK_DMISS_WR: ofs = `OFS_DMISS_WR;
      `RK_DPROT_RD: ofs = `OFS_DPROT_RD;
      `RK_DPROT_WR: ofs = `OFS_DPROT_WR;
      `RK_DMOD: ofs = `OFS_DMOD;
      default: ofs = `OFS_UNRECOV;
    endcase
    return ofs;
  endfunction

  // True for ranks that return to the first non-completed instruction.
  function automatic logic ret_to_pending(input logic [4:0] rank);
    return (rank == `RK_DEBUG) || (rank == `RK_BKPT) ||
           ((rank >= `RK_BUS_DATA) && (rank <= `RK_INT0));
  endfunction

  // True for the four interrupt levels.
  function automatic logic is_int(input logic [4:0] rank);
    return (rank >= `RK_INT3) && (rank <= `RK_INT0);
  endfunction

  // Events that the present mask bits block; critical events never appear.
  function automatic logic [`EVT_COUNT-1:0] blocked(input logic [`MASK_WIDTH-1:0] m);
    logic [`EVT_COUNT-1:0] b;
    b = '0;
    b[`RK_DEBUG] = m[`MB_DM];
    for (int n = 0; n < 4; n++) begin
      b[`RK_INT0 - 5'(n)] = m[n] | m[`MB_GM];
    end
    return b;
  endfunction

  // Mask bits set on acceptance: a level and all below it for an interrupt, bits 0 to 5 otherwise; only DM for a debug stop; none for a supervisor call.
  function automatic logic [`MASK_WIDTH-1:0] accept_mask(input logic [4:0] rank);
    logic [`MASK_WIDTH-1:0] s;
    s = '0;
    if (rank == `RK_DEBUG) begin
      s[`MB_DM] = 1'b1;
    end else if (is_int(rank)) begin
      for (int n = 0; n < 4; n++) begin
        s[n] = (5'(n) <= (`RK_INT0 - rank));
      end
    end else if (rank != `RK_SCALL) begin
      s = ~`MASK_RESET ^ {`MASK_WIDTH{1'b1}};
    end
    return s;
  endfunction

  // ---------------------------------------------------------------------------
  // Stage arbitration
  // ---------------------------------------------------------------------------
  vec_state_t st;
  vec_state_t next_st;
  logic [STW-1:0] oldest_valid;
  logic [STW-1:0] sel_stage;
  logic [NUM_STAGES-1:0][`EVT_COUNT-1:0] vec;
  logic [`EVT_COUNT-1:0] async_vec;
  logic [`EVT_COUNT-1:0] sel_vec;
  logic sel_found;
  logic [4:0] sel_rank;

  // Asynchronous requests belong to the first non-completed instruction.
  always_comb begin
    async_vec = '0;
    async_vec[`RK_DEBUG] = debug_stop_i;
    async_vec[`RK_NMI] = nmi_i;
    for (int n = 0; n < 4; n++) begin
      async_vec[`RK_INT0 - 5'(n)] = int_req_i[n];
    end
  end

  // The highest stage index holds the instruction issued earliest.
  always_comb begin
    oldest_valid = STW'(NUM_STAGES - 1);
    for (int s = 0; s < NUM_STAGES; s++) begin
      if (stage_i[s].valid) begin
        oldest_valid = STW'(s);
      end
    end
  end

  // Builds masked per-stage vectors and picks the oldest stage with work.
  always_comb begin
    sel_stage = '0;
    for (int s = 0; s < NUM_STAGES; s++) begin
      vec[s] = stage_i[s].valid ? stage_i[s].events : '0;
      if (STW'(s) == oldest_valid) begin
        vec[s] = vec[s] | async_vec;
      end
      vec[s][`RK_RESET] = 1'b0;
      vec[s][`RK_FLOAT] = 1'b0;
      vec[s][`RK_DMOD] = 1'b0;
      vec[s] = vec[s] & ~blocked(st.mask);
      if (|vec[s]) begin
        sel_stage = STW'(s);
      end
    end
    sel_vec = vec[sel_stage];
  end

  event_rank_select u_rank (
    .events_i(sel_vec),
    .found_o(sel_found),
    .rank_o(sel_rank)
  );

  // ---------------------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------------------
  logic [STW-1:0] next_stage;
  logic [STW-1:0] stage_q;

  // Forms the next state; a mask set in the same cycle as a clear wins.
  always_comb begin
    next_st = st;
    next_stage = stage_q;
    next_st.redirect = 1'b0;
    next_st.mask = st.mask & ~mask_clear_i;
    case (st.fsm)
      S_BOOT: begin
        next_st.redirect = 1'b1;
        next_st.target = `BOOT_ADDR;
        next_st.rank = `RK_RESET;
        next_st.ret_addr = '0;
        next_st.hold = `FLUSH_CYCLES;
        next_st.fsm = S_HOLD;
      end
      S_IDLE: begin
        if (sel_found) begin
          next_st.redirect = 1'b1;
          next_st.rank = sel_rank;
          next_stage = sel_stage;
          if (sel_rank == `RK_DEBUG) begin
            next_st.target = debug_addr_i;
          end else if (is_int(sel_rank)) begin
            next_st.target = event_vector_base_i |
                             {18'h0_0000, int_offset_i};
          end else begin
            next_st.target = event_vector_base_i |
                             {18'h0_0000, rank_offset(sel_rank)};
          end
          if (ret_to_pending(sel_rank)) begin
            next_st.ret_addr = first_pending_pc_i;
          end else if (sel_rank == `RK_SCALL) begin
            next_st.ret_addr = stage_i[sel_stage].pc + `SCALL_PC_STEP;
          end else begin
            next_st.ret_addr = stage_i[sel_stage].pc;
          end
          next_st.mask = next_st.mask | accept_mask(sel_rank);
          next_st.hold = `FLUSH_CYCLES;
          next_st.fsm = S_HOLD;
        end
      end
      S_HOLD: begin
        next_st.hold = st.hold - 2'h1;
        if (st.hold == 2'h1) begin
          next_st.fsm = S_IDLE;
        end
      end
      default: begin
        next_st.fsm = S_BOOT;
      end
    endcase
  end

  // Reset wins over every event and restarts at the boot address.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '{fsm: S_BOOT, mask: `MASK_RESET, redirect: 1'b0, target: '0,
              ret_addr: '0, rank: `RK_RESET, hold: 2'h0};
      stage_q <= '0;
    end else begin
      st <= next_st;
      stage_q <= next_stage;
    end
  end

  // Outputs come straight from the state register.
  assign redirect_o = st.redirect;
  assign target_o = st.target;
  assign ret_addr_o = st.ret_addr;
  assign accept_rank_o = st.rank;
  assign accept_stage_o = stage_q;
  assign mask_o = st.mask;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  boot_fetch_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $past(sys_rst_i) |-> ##1 (redirect_o && target_o == `BOOT_ADDR))
    else $error("Boot redirect missing after reset.");

  scall_target_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (redirect_o && accept_rank_o == `RK_SCALL) |->
      target_o == ($past(event_vector_base_i) | 32'h0000_0100))
    else $error("Supervisor call target wrong.");

  int_target_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (redirect_o && is_int(accept_rank_o)) |->
      target_o == ($past(event_vector_base_i) | {18'h0_0000, $past(int_offset_i)}))
    else $error("Interrupt target wrong.");

  unused_slot_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    redirect_o |-> (accept_rank_o != `RK_FLOAT && accept_rank_o != `RK_DMOD))
    else $error("Unused exception slot raised.");

  oldest_first_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (redirect_o && accept_rank_o >= `RK_INSTR_ADDR && accept_stage_o == '0 &&
     $past(stage_i[NUM_STAGES-1].valid) && NUM_STAGES > 1) |->
      ($past(stage_i[NUM_STAGES-1].events) & ~28'h804_0001) == '0)
    else $error("Younger instruction served before older one.");

  int_mask_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (redirect_o && accept_rank_o == `RK_INT3) |-> mask_o[3:0] == 4'hf)
    else $error("Interrupt levels not masked on acceptance.");

  nmi_taken_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (st.fsm == S_IDLE && nmi_i) |=> (redirect_o && accept_rank_o <= `RK_NMI))
    else $error("NMI not accepted.");

  rank_order_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (st.fsm == S_IDLE && sel_vec[`RK_UNRECOV]) |=> accept_rank_o <= `RK_UNRECOV)
    else $error("Lower ranked event beat unrecoverable fault.");

  bus_return_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (redirect_o && accept_rank_o == `RK_BUS_DATA) |->
      ret_addr_o == $past(first_pending_pc_i))
    else $error("Bus error return address wrong.");

  flush_gap_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    redirect_o |=> !redirect_o ##1 !redirect_o)
    else $error("Redirects closer than the flush window.");

  debug_target_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (redirect_o && accept_rank_o == `RK_DEBUG) |-> target_o == $past(debug_addr_i))
    else $error("Debug stop target wrong.");

  exc_mask_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (redirect_o && accept_rank_o == `RK_ILLEGAL) |-> mask_o[5:0] == 6'h3f)
    else $error("Exception acceptance left mask bits clear.");

endmodule

/* File: tb/int_ctrl_model.sv */
/*
  Interrupt controller model: keeps level requests pending until accepted, gives the offset.
  Assumes the unit under test reports acceptance by redirect pulse and accepted rank.
*/
`timescale 1ns/10ps

module int_ctrl_model
  import evt_vec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] raise_i,
  input wire logic [3:0][`OFS_WIDTH-1:0] level_ofs_i,
  input wire logic redirect_i,
  input wire logic [4:0] accept_rank_i,
  output logic [3:0] int_req_o,
  output logic [`OFS_WIDTH-1:0] int_offset_o
);
  logic [`OFS_WIDTH-1:0] junk;

  // Requests stay up until the unit accepts that level; junk inverts every cycle out of reset.
  always_ff @(posedge clk_sys_i) begin
    junk <= sys_rst_i ? 14'h2a5a : ~junk;
    for (int n = 0; n < 4; n++) begin
      if (sys_rst_i) begin
        int_req_o[n] <= 1'b0;
      end else if (raise_i[n]) begin
        int_req_o[n] <= 1'b1;
      end else if (redirect_i && accept_rank_i == 5'(`RK_INT0 - n)) begin
        int_req_o[n] <= 1'b0;
      end
    end
  end

  // Offset of the highest pending level, no stable value when none pends.
  always_comb begin
    int_offset_o = junk;
    for (int n = 0; n < 4; n++) begin
      if (int_req_o[n]) begin
        int_offset_o = level_ofs_i[n];
      end
    end
  end
endmodule

/* File: tb/event_priority_vectoring_test.sv */
/*
  Self-checking bench of the event priority and vectoring unit.
  Assumes the package and defines header are compiled first.
*/
`timescale 1ns/10ps

module event_priority_vectoring_test
  import evt_vec_pkg::*;
;
  logic clk_sys_i, sys_rst_i, debug_stop, nmi, redirect, got;
  stage_evt_t [2:0] stg;
  logic [31:0] debug_addr, base, fpc, target, ret_addr, pc;
  logic [3:0] int_req, raise;
  logic [3:0][`OFS_WIDTH-1:0] lofs;
  logic [`OFS_WIDTH-1:0] int_ofs;
  logic [6:0] mclr, mask;
  logic [4:0] rank;
  logic [1:0] stage;
  logic [31:0] seed = 32'h561b_caff;
  int n_fail = 0;
  int n_checks = 0;

  event_priority_vectoring #(.NUM_STAGES(3)) event_priority_vectoring_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .stage_i(stg),
    .debug_stop_i(debug_stop), .debug_addr_i(debug_addr), .nmi_i(nmi),
    .int_req_i(int_req), .int_offset_i(int_ofs), .event_vector_base_i(base),
    .first_pending_pc_i(fpc), .mask_clear_i(mclr), .redirect_o(redirect),
    .target_o(target), .ret_addr_o(ret_addr), .accept_rank_o(rank),
    .accept_stage_o(stage), .mask_o(mask)
  );

  int_ctrl_model int_ctrl_model_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .raise_i(raise),
    .level_ofs_i(lofs), .redirect_i(redirect), .accept_rank_i(rank),
    .int_req_o(int_req), .int_offset_o(int_ofs)
  );

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  // Xorshift source of repeatable random values.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Handler offset of each fixed-vector rank the bench raises.
  function automatic logic [13:0] exp_ofs(input logic [4:0] r);
    case (r)
      `RK_UNRECOV: return 14'h0000;
      `RK_MULTI_HIT: return 14'h0004;
      `RK_BUS_DATA: return 14'h0008;
      `RK_BUS_INSTR: return 14'h000c;
      `RK_NMI: return 14'h0010;
      `RK_INSTR_ADDR: return 14'h0014;
      `RK_IMISS: return 14'h0050;
      `RK_IPROT: return 14'h0018;
      `RK_BKPT: return 14'h001c;
      `RK_ILLEGAL: return 14'h0020;
      `RK_UNIMPL: return 14'h0024;
      `RK_PRIV: return 14'h0028;
      `RK_COPROC: return 14'h0030;
      `RK_SCALL: return 14'h0100;
      `RK_DADDR_RD: return 14'h0034;
      `RK_DADDR_WR: return 14'h0038;
      `RK_DMISS_RD: return 14'h0060;
      `RK_DMISS_WR: return 14'h0070;
      `RK_DPROT_RD: return 14'h003c;
      default: return 14'h0040;
    endcase
  endfunction

  // Saved return address for an exception raised by the instruction at p.
  function automatic logic [31:0] exp_ret(input logic [4:0] r, input logic [31:0] p);
    if (r == `RK_SCALL) return p + 32'h0000_0002;
    if (r == `RK_BUS_DATA || r == `RK_BUS_INSTR || r == `RK_BKPT) return fpc;
    return p;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Waits a bounded number of cycles for a redirect pulse.
  task automatic wait_redir(input int lim);
    got = 1'b0;
    repeat (lim) begin
      @(negedge clk_sys_i);
      raise = 4'h0;
      mclr = 7'h00;
      if (redirect === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask

  // A redirect must come; its fields are compared with the expected ones.
  task automatic expect_redir(input logic [31:0] t, input logic [31:0] r, input logic [4:0] k,
                              input logic [6:0] m);
    wait_redir(20);
    if (!got) begin
      check(32'h0, 32'h1);
      complete_run();
    end
    check(target, t);
    check(ret_addr, r);
    check({27'h0, rank}, {27'h0, k});
    check({25'h0, mask}, {25'h0, m});
  endtask

  task automatic expect_none();
    wait_redir(10);
    check({31'h0, got}, 32'h0);
  endtask

  // Drops stage, debug and NMI sources and clears all mask bits.
  task automatic release_all();
    stg = '0;
    debug_stop = 1'b0;
    nmi = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    mclr = 7'h7f;
    @(negedge clk_sys_i);
    mclr = 7'h00;
    repeat (3) @(negedge clk_sys_i);
  endtask

  // -------------------------------------------------------------------------
  // Clock and main sequence
  // -------------------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    {sys_rst_i, stg, debug_stop, nmi, debug_addr, raise, lofs, mclr} = '0;
    sys_rst_i = 1'b1;
    base = rnd();
    fpc = rnd();
    repeat (20) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    wait_redir(10);
    check(target, `BOOT_ADDR);
    check({27'h0, rank}, 32'h0);
    release_all();
    // Every fixed-vector exception but the unused FLOAT and DMOD slots, in the oldest stage, with lower ones beside it
    // and random events on younger stages.
    for (int r = 2; r < 27; r++) begin
      if ((r >= 6 && r <= 10) || r == 18) continue;
      base = rnd();
      fpc = rnd();
      pc = rnd() & 32'hffff_fffe;
      stg[2] = {1'b1, pc, 28'(28'h1 << r) | 28'(rnd() << (r + 1))};
      stg[1] = {rnd() % 2 == 0, rnd(), 28'(rnd())};
      stg[0] = {1'b1, rnd(), 28'(rnd()) & 28'hfff_fffe};
      expect_redir(base | {18'h0, exp_ofs(5'(r))}, exp_ret(5'(r), pc), 5'(r),
                   (r == 20) ? 7'h00 : 7'h3f);
      check({30'h0, stage}, 32'h2);
      release_all();
    end
    // Unused slots raise nothing.
    stg[2] = {1'b1, rnd(), 28'h804_0000};
    expect_none();
    release_all();
    // A valid but quiet oldest stage lets a younger one through.
    pc = rnd() & 32'hffff_fffe;
    stg[2] = {1'b1, rnd(), 28'h000_0000};
    stg[0] = {1'b1, pc, 28'h1 << `RK_ILLEGAL};
    expect_redir(base | 32'h0000_0020, pc, `RK_ILLEGAL, 7'h3f);
    check({30'h0, stage}, 32'h0);
    release_all();
    // Each interrupt level vectors through the controller offset.
    for (int n = 3; n >= 0; n--) begin
      lofs[n] = 14'(rnd());
      raise[n] = 1'b1;
      expect_redir(base | {18'h0, lofs[n]}, fpc, 5'(`RK_INT0 - n),
                   7'(4'((5'h2 << n) - 5'h1)));
      release_all();
    end
    // A masked level waits while the non-maskable interrupt still gets through.
    raise[3] = 1'b1;
    expect_redir(base | {18'h0, lofs[3]}, fpc, `RK_INT3, 7'h0f);
    raise[0] = 1'b1;
    expect_none();
    nmi = 1'b1;
    wait_redir(20);
    check(target, base | 32'h0000_0010);
    check({27'h0, rank}, {27'h0, `RK_NMI});
    // The level left pending is taken once its mask bits are cleared.
    nmi = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    mclr = 7'h7f;
    expect_redir(base | {18'h0, lofs[0]}, fpc, `RK_INT0, 7'h01);
    release_all();
    // Debug stop uses its own address and then blocks itself.
    debug_addr = rnd();
    debug_stop = 1'b1;
    expect_redir(debug_addr, fpc, `RK_DEBUG, 7'h40);
    expect_none();
    release_all();
    // A second reset in mid-run restarts at the boot address with the reset mask.
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    wait_redir(10);
    check({31'h0, got}, 32'h1);
    check(target, `BOOT_ADDR);
    check({25'h0, mask}, {25'h0, `MASK_RESET});
    complete_run();
  end
endmodule
